// ---- hdl/gdm_device_end.sv ----
// Gate driver control end: PWM pass-through, enable and mode control,
// fault latch and pin, wake detection and serial configuration.
// Assumes every pin input is asynchronous to sys_clk.
`timescale 1ns/100ps
module gdm_device_end #(
   parameter logic [15:0] BIT_CYCLES = gdm_pkg::BIT_CYCLES,
   parameter logic [15:0] OE_LOW_CYCLES = gdm_pkg::OE_LOW_CYCLES,
   parameter logic [15:0] WAKE_SETUP_CYCLES = gdm_pkg::WAKE_SETUP_CYCLES,
   parameter logic [15:0] STARTUP_CYCLES = gdm_pkg::STARTUP_CYCLES
) (
   input wire logic sys_clk,
   input wire logic reset,
   gdm_link_if.dev pins,
   input wire logic faultCondition,
   output logic bootstrapSupplyEn,
   output logic chargePumpEn,
   output logic ampEnable,
   output logic regulatorEnable,
   output logic [1:0] modeState,
   output logic [7:0] configReg
);

   typedef gdm_pkg::gdm_link_s gdm_link_s;

   typedef enum logic [1:0] {
      MODE_START, MODE_NORMAL, MODE_STANDBY, MODE_SLEEP
   } gdm_mode_e;

   typedef struct packed {
      gdm_mode_e mode;
      logic [1:0] oeSync;
      logic [1:0] wakeSync;
      logic [1:0] faultSync;
      logic [1:0] lineLowSync;
      logic [5:0] pwmMeta;
      logic [5:0] pwmSync;
      logic oePrev;
      logic wakePrev;
      logic [15:0] oeLowCnt;
      logic [15:0] wakeLowCnt;
      logic [15:0] startCnt;
      logic faultLatch;
      logic faultPinLow;
      logic [7:0] cfg;
      logic replyPend;
      gdm_link_s link;
      logic [5:0] gate;
      logic [5:0][3:0] dtCnt;
      logic supplyEn;
      logic ampEn;
      logic regEn;
   } gdm_dev_s;

   gdm_dev_s state_reg;
   gdm_dev_s state_next;
   logic [5:0] pwmPins;
   logic oeHigh;
   logic oeRise;
   logic oeLowDone;
   logic wakeRise;
   logic wakeArmed;
   logic driveOn;
   logic [3:0] deadTime;
   logic [7:0] statusByte;

   // Pin gathering in gate bit order
   assign pwmPins[gdm_pkg::GATE_AH] = pins.phaseAHighDriveIn;
   assign pwmPins[gdm_pkg::GATE_AL] = pins.phaseALowDriveIn;
   assign pwmPins[gdm_pkg::GATE_BH] = pins.phaseBHighDriveIn;
   assign pwmPins[gdm_pkg::GATE_BL] = pins.phaseBLowDriveIn;
   assign pwmPins[gdm_pkg::GATE_CH] = pins.phaseCHighDriveIn;
   assign pwmPins[gdm_pkg::GATE_CL] = pins.phaseCLowDriveIn;

   // Next-state logic
   always_comb begin
      state_next = state_reg;
      oeHigh = state_reg.oeSync[1];
      oeRise = oeHigh && !state_reg.oePrev;
      oeLowDone = state_reg.oeLowCnt == OE_LOW_CYCLES;
      wakeRise = state_reg.wakeSync[1] && !state_reg.wakePrev;
      wakeArmed = state_reg.wakeLowCnt == WAKE_SETUP_CYCLES;
      driveOn = (state_reg.mode == MODE_NORMAL) && oeHigh;
      deadTime = state_reg.cfg[gdm_pkg::CFG_DEAD_LSB +: 4];
      statusByte = {5'h00, state_reg.faultLatch, state_reg.mode};

      // Two-stage synchronisers on every pin input
      state_next.oeSync = {state_reg.oeSync[0], pins.outputEnable};
      state_next.wakeSync = {state_reg.wakeSync[0], pins.wakeIn};
      state_next.faultSync = {state_reg.faultSync[0], faultCondition};
      state_next.lineLowSync = {state_reg.lineLowSync[0], !pins.lineLevel};
      state_next.pwmMeta = pwmPins;
      state_next.pwmSync = state_reg.pwmMeta;
      state_next.oePrev = oeHigh;
      state_next.wakePrev = state_reg.wakeSync[1];

      // Enable-low timer, held clear while asleep or starting
      if (oeHigh || state_reg.mode == MODE_SLEEP ||
         state_reg.mode == MODE_START) begin
         state_next.oeLowCnt = 16'h0000;
      end else if (!oeLowDone) begin
         state_next.oeLowCnt = state_reg.oeLowCnt + 16'h0001;
      end

      // Wake pin must sit low for the setup time before its rise
      if (state_reg.wakeSync[1]) begin
         state_next.wakeLowCnt = 16'h0000;
      end else if (!wakeArmed) begin
         state_next.wakeLowCnt = state_reg.wakeLowCnt + 16'h0001;
      end

      // Operating mode sequencing
      unique case (state_reg.mode)
         MODE_START: begin
            state_next.startCnt = state_reg.startCnt + 16'h0001;
            if (state_reg.startCnt == STARTUP_CYCLES - 16'h0001) begin
               state_next.mode = MODE_NORMAL;
               state_next.startCnt = 16'h0000;
            end
         end
         MODE_NORMAL: begin
            if (oeLowDone) begin
               state_next.mode = state_reg.cfg[gdm_pkg::CFG_SLEEP_BIT] ?
                  MODE_SLEEP : MODE_STANDBY;
            end
         end
         MODE_STANDBY: begin
            if (oeHigh) begin
               state_next.mode = MODE_NORMAL;
            end
         end
         MODE_SLEEP: begin
            if (wakeRise && wakeArmed) begin
               state_next.mode = MODE_START;
            end
         end
      endcase

      // Supplies and amplifiers follow the next mode
      state_next.supplyEn = state_next.mode == MODE_NORMAL;
      state_next.ampEn = (state_next.mode == MODE_NORMAL) ||
         (state_next.mode == MODE_START) ||
         ((state_next.mode == MODE_STANDBY) &&
         !state_reg.cfg[gdm_pkg::CFG_AMP_OFF_BIT]);
      state_next.regEn = state_next.mode != MODE_SLEEP;

      // Gate outputs with optional dead-time insertion per phase
      for (int i = 0; i < 6; i++) begin
         if (state_reg.pwmSync[i] && !state_reg.gate[i ^ 1]) begin
            if (state_reg.dtCnt[i] != gdm_pkg::DEAD_MAX) begin
               state_next.dtCnt[i] = state_reg.dtCnt[i] + 4'h1;
            end
         end else begin
            state_next.dtCnt[i] = 4'h0;
         end
         state_next.gate[i] = driveOn && state_reg.pwmSync[i] &&
            ((deadTime == gdm_pkg::DEAD_ZERO) ||
            (!state_reg.gate[i ^ 1] &&
            state_reg.dtCnt[i] >= deadTime));
      end

      // Fault latch: a present fault wins over the enable-rise clear
      if (state_reg.faultSync[1]) begin
         state_next.faultLatch = 1'b1;
      end else if (oeRise) begin
         state_next.faultLatch = 1'b0;
      end
      state_next.faultPinLow = state_next.faultLatch ||
         (state_next.mode == MODE_START);

      // Serial link: a received byte becomes config, then a reply
      if (state_reg.replyPend && state_reg.link.st == gdm_pkg::LINK_IDLE) begin
         state_next.replyPend = 1'b0;
      end
      if (state_reg.link.rxDone) begin
         state_next.cfg = state_reg.link.rxByte;
         state_next.replyPend = 1'b1;
      end
      state_next.link = gdm_pkg::gdm_link_step(state_reg.link,
         !state_reg.lineLowSync[1], state_reg.replyPend, statusByte,
         BIT_CYCLES);
   end

   // State register; all-zero is start-up, idle link, gates off
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign pins.phaseAHighGateOut = state_reg.gate[gdm_pkg::GATE_AH];
   assign pins.phaseALowGateOut = state_reg.gate[gdm_pkg::GATE_AL];
   assign pins.phaseBHighGateOut = state_reg.gate[gdm_pkg::GATE_BH];
   assign pins.phaseBLowGateOut = state_reg.gate[gdm_pkg::GATE_BL];
   assign pins.phaseCHighGateOut = state_reg.gate[gdm_pkg::GATE_CH];
   assign pins.phaseCLowGateOut = state_reg.gate[gdm_pkg::GATE_CL];
   assign pins.devFaultOut = 1'b0; // Open drain: only ever low
   assign pins.devFaultOe = state_reg.faultPinLow;
   assign pins.devLineOut = 1'b0;
   assign pins.devLineOe = state_reg.link.drvLow;
   assign bootstrapSupplyEn = state_reg.supplyEn;
   assign chargePumpEn = state_reg.supplyEn;
   assign ampEnable = state_reg.ampEn;
   assign regulatorEnable = state_reg.regEn;
   assign modeState = state_reg.mode;
   assign configReg = state_reg.cfg;

endmodule // gdm_device_end

// ---- hdl/gdm_host_end.sv ----
// Host controller end: drives PWM, enable and wake pins, watches the
// fault pin and runs the serial link. User side is on sys_clk.
`timescale 1ns/100ps
module gdm_host_end #(
   parameter logic [15:0] BIT_CYCLES = gdm_pkg::BIT_CYCLES
) (
   input wire logic sys_clk,
   input wire logic reset,
   gdm_link_if.host pins,
   input wire logic [5:0] pwmCmd,
   input wire logic outputEnableCmd,
   input wire logic wakeCmd,
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady,
   output logic rxValid,
   output logic [7:0] rxData,
   output logic faultActive
);

   typedef gdm_pkg::gdm_link_s gdm_link_s;

   typedef struct packed {
      logic [5:0] pwm;
      logic oe;
      logic wake;
      logic [1:0] faultLowSync;
      logic [1:0] lineLowSync;
      gdm_link_s link;
      logic txRdy;
   } gdm_host_s;

   gdm_host_s state_reg;
   gdm_host_s state_next;

   // Next-state logic
   always_comb begin
      state_next = state_reg;
      state_next.pwm = pwmCmd;
      state_next.oe = outputEnableCmd;
      state_next.wake = wakeCmd;
      state_next.faultLowSync = {state_reg.faultLowSync[0],
         !pins.faultLevel};
      state_next.lineLowSync = {state_reg.lineLowSync[0], !pins.lineLevel};
      state_next.link = gdm_pkg::gdm_link_step(state_reg.link,
         !state_reg.lineLowSync[1], txValid && state_reg.txRdy, txData,
         BIT_CYCLES);
      state_next.txRdy = state_next.link.st == gdm_pkg::LINK_IDLE;
   end

   // State register
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Outputs straight from the state register
   assign pins.phaseAHighDriveIn = state_reg.pwm[gdm_pkg::GATE_AH];
   assign pins.phaseALowDriveIn = state_reg.pwm[gdm_pkg::GATE_AL];
   assign pins.phaseBHighDriveIn = state_reg.pwm[gdm_pkg::GATE_BH];
   assign pins.phaseBLowDriveIn = state_reg.pwm[gdm_pkg::GATE_BL];
   assign pins.phaseCHighDriveIn = state_reg.pwm[gdm_pkg::GATE_CH];
   assign pins.phaseCLowDriveIn = state_reg.pwm[gdm_pkg::GATE_CL];
   assign pins.outputEnable = state_reg.oe;
   assign pins.wakeIn = state_reg.wake;
   assign pins.hostLineOut = 1'b0;
   assign pins.hostLineOe = state_reg.link.drvLow;
   assign txReady = state_reg.txRdy;
   assign rxValid = state_reg.link.rxDone;
   assign rxData = state_reg.link.rxByte;
   assign faultActive = state_reg.faultLowSync[1];

endmodule // gdm_host_end

// ---- hdl/gdm_link_if.sv ----
// Pins between the gate driver and its host controller.
// Resolves the open-drain serial and fault wires with their pull-ups.
`timescale 1ns/100ps
interface gdm_link_if;
   logic phaseAHighDriveIn;
   logic phaseALowDriveIn;
   logic phaseBHighDriveIn;
   logic phaseBLowDriveIn;
   logic phaseCHighDriveIn;
   logic phaseCLowDriveIn;
   logic outputEnable;
   logic wakeIn;
   logic phaseAHighGateOut;
   logic phaseALowGateOut;
   logic phaseBHighGateOut;
   logic phaseBLowGateOut;
   logic phaseCHighGateOut;
   logic phaseCLowGateOut;
   logic devFaultOut;
   logic devFaultOe;
   logic devLineOut;
   logic devLineOe;
   logic hostLineOut;
   logic hostLineOe;
   logic faultLevel;
   logic lineLevel;

   // Pull-ups: a wire is high unless some end drives it low
   assign faultLevel = !(devFaultOe && !devFaultOut);
   assign lineLevel = !((devLineOe && !devLineOut) ||
      (hostLineOe && !hostLineOut));

   modport dev (
      input phaseAHighDriveIn, phaseALowDriveIn, phaseBHighDriveIn,
      input phaseBLowDriveIn, phaseCHighDriveIn, phaseCLowDriveIn,
      input outputEnable, wakeIn, lineLevel,
      output phaseAHighGateOut, phaseALowGateOut, phaseBHighGateOut,
      output phaseBLowGateOut, phaseCHighGateOut, phaseCLowGateOut,
      output devFaultOut, devFaultOe, devLineOut, devLineOe
   );

   modport host (
      output phaseAHighDriveIn, phaseALowDriveIn, phaseBHighDriveIn,
      output phaseBLowDriveIn, phaseCHighDriveIn, phaseCLowDriveIn,
      output outputEnable, wakeIn, hostLineOut, hostLineOe,
      input faultLevel, lineLevel
   );
endinterface

// ---- hdl/gdm_pkg.sv ----
// Shared constants, types and serial link engine for both ends of the
// gate drive link. Assumes one 40 MHz clock common to both ends.
package gdm_pkg;

   // Clock and timing
   localparam int CLK_HZ = 40_000_000;
   localparam int BAUD_RATE = 9600;
   localparam logic [15:0] BIT_CYCLES = 16'(CLK_HZ / BAUD_RATE);
   localparam int OE_LOW_TIME_US = 1000;
   localparam logic [15:0] OE_LOW_CYCLES =
      16'(CLK_HZ / 1_000_000 * OE_LOW_TIME_US);
   localparam logic [15:0] WAKE_SETUP_CYCLES = 16'h0190;
   localparam logic [15:0] STARTUP_CYCLES = 16'h0040;

   // Gate and PWM bit positions; partner of bit i is bit i^1
   localparam int GATE_AH = 0;
   localparam int GATE_AL = 1;
   localparam int GATE_BH = 2;
   localparam int GATE_BL = 3;
   localparam int GATE_CH = 4;
   localparam int GATE_CL = 5;

   // Configuration byte layout
   localparam int CFG_SLEEP_BIT = 0;
   localparam int CFG_AMP_OFF_BIT = 1;
   localparam int CFG_DEAD_LSB = 4;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [3:0] DEAD_ZERO = 4'h0;
   localparam logic [3:0] DEAD_MAX = 4'hF;

   // Serial frame: start, 8 data, stop
   localparam logic [3:0] LAST_BIT_IDX = 4'h9;

   typedef enum logic [1:0] {LINK_IDLE, LINK_RX, LINK_TX} gdm_link_e;

   typedef struct packed {
      gdm_link_e st;
      logic [15:0] timer;
      logic [3:0] idx;
      logic [9:0] shift;
      logic [7:0] rxByte;
      logic rxDone;
      logic drvLow;
   } gdm_link_s;

   // One clock step of the half-duplex 8N1 engine
   function automatic gdm_link_s gdm_link_step(
      gdm_link_s c,
      logic lineIn,
      logic txReq,
      logic [7:0] txByte,
      logic [15:0] bitCyc
   );
      gdm_link_s n;
      n = c;
      n.rxDone = 1'b0;
      unique case (c.st)
         LINK_IDLE: begin
            if (txReq) begin
               n.st = LINK_TX;
               n.shift = {1'b1, txByte, 1'b0};
               n.timer = bitCyc - 16'h0001;
               n.idx = 4'h0;
            end else if (!lineIn) begin
               n.st = LINK_RX; // Sample bits mid-cell
               n.timer = bitCyc >> 1;
               n.idx = 4'h0;
            end
         end
         LINK_RX: begin
            if (c.timer != 16'h0000) begin
               n.timer = c.timer - 16'h0001;
            end else begin
               n.timer = bitCyc - 16'h0001;
               n.idx = c.idx + 4'h1;
               if (c.idx == 4'h0 && lineIn) begin
                  n.st = LINK_IDLE; // False start
               end else if (c.idx == LAST_BIT_IDX) begin
                  n.st = LINK_IDLE;
                  n.rxDone = lineIn; // Bad stop bit drops byte
               end else if (c.idx != 4'h0) begin
                  n.rxByte = {lineIn, c.rxByte[7:1]};
               end
            end
         end
         LINK_TX: begin
            if (c.timer != 16'h0000) begin
               n.timer = c.timer - 16'h0001;
            end else begin
               n.timer = bitCyc - 16'h0001;
               n.shift = {1'b1, c.shift[9:1]};
               n.idx = c.idx + 4'h1;
               if (c.idx == LAST_BIT_IDX) begin
                  n.st = LINK_IDLE;
               end
            end
         end
      endcase
      n.drvLow = (n.st == LINK_TX) && !n.shift[0];
      return n;
   endfunction

endpackage

// ---- testbench/gate_drive_enable_mode_control_tb_top.sv ----
// Bench top: both link ends, the link interface and the checker.
// Assumes shortened counts; serial replies are queued and compared.
`timescale 1ns/100ps
`define GDM_CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin \
   n_errors++; $display("MISMATCH %s exp %0h seen %0h", nm, e, a); end end
module gate_drive_enable_mode_control_tb_top;
   localparam logic [15:0] BIT_CYC = 16'h0010;
   localparam logic [15:0] OE_LOW = 16'h00C8;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic faultCondition = 1'b0;
   logic [5:0] pwmCmd = 6'h00;
   logic oeCmd = 1'b0;
   logic wakeCmd = 1'b0;
   logic txValid = 1'b0;
   logic [7:0] txData = 8'h00;
   logic txReady;
   logic rxValid;
   logic faultActive;
   logic [7:0] rxData;
   logic [7:0] configReg;
   logic [1:0] modeState;
   logic bootEn;
   logic pumpEn;
   logic ampEn;
   logic regEn;
   logic [5:0] gateVec;
   logic [5:0] pwmVal;
   logic [7:0] expByte;
   logic [7:0] expQ[$];
   int n_errors = 0;
   int cmp_count = 0;
   int seed = 32;
   gdm_link_if pins();

   gdm_device_end #(.BIT_CYCLES(BIT_CYC), .OE_LOW_CYCLES(OE_LOW),
      .WAKE_SETUP_CYCLES(16'h0008), .STARTUP_CYCLES(16'h0008))
   i_gdm_device_end (.sys_clk(sys_clk), .reset(reset), .pins(pins),
      .faultCondition(faultCondition), .bootstrapSupplyEn(bootEn),
      .chargePumpEn(pumpEn), .ampEnable(ampEn), .regulatorEnable(regEn),
      .modeState(modeState), .configReg(configReg));
   gdm_host_end #(.BIT_CYCLES(BIT_CYC)) i_gdm_host_end (.sys_clk(sys_clk),
      .reset(reset), .pins(pins), .pwmCmd(pwmCmd), .outputEnableCmd(oeCmd),
      .wakeCmd(wakeCmd), .txValid(txValid), .txData(txData),
      .txReady(txReady), .rxValid(rxValid), .rxData(rxData),
      .faultActive(faultActive));
   gdm_link_asserts #(.OE_LOW_CYCLES(int'(OE_LOW))) i_gdm_link_asserts (
      .sys_clk(sys_clk), .reset(reset),
      .phaseAHighDriveIn(pins.phaseAHighDriveIn),
      .phaseALowDriveIn(pins.phaseALowDriveIn),
      .phaseAHighGateOut(pins.phaseAHighGateOut),
      .phaseALowGateOut(pins.phaseALowGateOut),
      .phaseBHighGateOut(pins.phaseBHighGateOut),
      .phaseBLowGateOut(pins.phaseBLowGateOut),
      .phaseCHighGateOut(pins.phaseCHighGateOut),
      .phaseCLowGateOut(pins.phaseCLowGateOut),
      .outputEnable(pins.outputEnable), .wakeIn(pins.wakeIn),
      .devFaultOut(pins.devFaultOut), .devFaultOe(pins.devFaultOe),
      .devLineOut(pins.devLineOut), .hostLineOut(pins.hostLineOut),
      .modeState(modeState), .bootstrapSupplyEn(bootEn),
      .chargePumpEn(pumpEn), .ampEnable(ampEn), .configReg(configReg));

   // Gate outputs in command bit order
   assign gateVec = {pins.phaseCLowGateOut, pins.phaseCHighGateOut,
      pins.phaseBLowGateOut, pins.phaseBHighGateOut,
      pins.phaseALowGateOut, pins.phaseAHighGateOut};

   // 40 MHz clock
   always #12.5 sys_clk = ~sys_clk;

   task automatic cycles(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Send one byte, note the reply, wait until it is compared
   task automatic sendByte(input logic [7:0] b, input logic [7:0] rep);
      int k;
      k = 0;
      expQ.push_back(rep);
      txValid <= 1'b1;
      txData <= b;
      do begin
         @(posedge sys_clk);
         k++;
      end while (txReady !== 1'b1 && k < 50);
      txValid <= 1'b0;
      while (expQ.size() != 0 && k < 3000) begin
         @(posedge sys_clk);
         k++;
      end
      `GDM_CHK("reply count", 0, expQ.size())
   endtask

   // Reply monitor; a reply with no note is a mismatch
   always @(posedge sys_clk) begin
      if (rxValid === 1'b1) begin
         if (expQ.size() == 0) begin
            n_errors++;
            $display("MISMATCH reply exp none seen %0h", rxData);
         end else begin
            expByte = expQ.pop_front();
            `GDM_CHK("reply", expByte, rxData)
         end
      end
   end

   // Watchdog
   initial begin
      cycles(8000);
      n_errors++;
      $display("MISMATCH watchdog exp done seen hang");
      summarize();
   end

   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      cycles(2);
      `GDM_CHK("startup fault", 1'b0, pins.faultLevel)
      oeCmd <= 1'b1;
      cycles(20);
      `GDM_CHK("mode", 2'h1, modeState)
      `GDM_CHK("fault", 1'b0, faultActive)
      for (int i = 0; i < 8; i++) begin
         pwmVal = 6'($random(seed));
         pwmVal = pwmVal & ~{pwmVal[4], 1'b0, pwmVal[2], 1'b0, pwmVal[0], 1'b0};
         pwmCmd <= pwmVal;
         cycles(8);
         `GDM_CHK("gates", pwmVal, gateVec)
      end
      pwmCmd <= 6'h15;
      cycles(8);
      oeCmd <= 1'b0;
      cycles(5);
      `GDM_CHK("gates off", 6'h00, gateVec)
      cycles(100);
      `GDM_CHK("mode", 2'h1, modeState)
      oeCmd <= 1'b1;
      cycles(8);
      `GDM_CHK("gates", 6'h15, gateVec)
      faultCondition <= 1'b1;
      cycles(8);
      `GDM_CHK("fault", 1'b1, faultActive)
      sendByte(8'h02, 8'h05);
      `GDM_CHK("config", 8'h02, configReg)
      oeCmd <= 1'b0;
      cycles(20);
      oeCmd <= 1'b1;
      cycles(10);
      `GDM_CHK("fault held", 1'b1, faultActive)
      faultCondition <= 1'b0;
      cycles(4);
      oeCmd <= 1'b0;
      cycles(20);
      oeCmd <= 1'b1;
      cycles(10);
      `GDM_CHK("fault clear", 1'b0, faultActive)
      `GDM_CHK("mode", 2'h1, modeState)
      oeCmd <= 1'b0;
      cycles(150);
      oeCmd <= 1'b1;
      cycles(4);
      oeCmd <= 1'b0;
      cycles(150);
      `GDM_CHK("mode", 2'h1, modeState)
      cycles(100);
      `GDM_CHK("standby", 2'h2, modeState)
      `GDM_CHK("supplies", 3'h0, {bootEn, pumpEn, ampEn})
      oeCmd <= 1'b1;
      cycles(8);
      `GDM_CHK("supplies", 2'h3, {bootEn, pumpEn})
      sendByte(8'h01, 8'h01);
      wakeCmd <= 1'b1;
      oeCmd <= 1'b0;
      cycles(260);
      `GDM_CHK("sleep", 2'h3, modeState)
      `GDM_CHK("regulator", 1'b0, regEn)
      oeCmd <= 1'b1;
      wakeCmd <= 1'b0;
      cycles(3);
      wakeCmd <= 1'b1;
      cycles(10);
      `GDM_CHK("sleep", 2'h3, modeState)
      wakeCmd <= 1'b0;
      cycles(20);
      wakeCmd <= 1'b1;
      cycles(30);
      `GDM_CHK("woken", 2'h1, modeState)
      // Dead time of 3 cycles holds the low gate back
      sendByte(8'h30, 8'h01);
      `GDM_CHK("config", 8'h30, configReg)
      pwmCmd <= 6'h02;
      cycles(6);
      `GDM_CHK("dead time", 6'h00, gateVec)
      cycles(6);
      `GDM_CHK("gates", 6'h02, gateVec)
      // Standby with amplifiers left running
      oeCmd <= 1'b0;
      cycles(215);
      `GDM_CHK("standby", 2'h2, modeState)
      `GDM_CHK("supplies", 3'h1, {bootEn, pumpEn, ampEn})
      summarize();
   end
endmodule // gate_drive_enable_mode_control_tb_top

// ---- testbench/gdm_link_asserts.sv ----
// Concurrent checks on the gate drive link and device mode outputs.
// Assumes one clock, instanced beside the link interface.
`timescale 1ns/100ps
module gdm_link_asserts #(
   parameter int OE_LOW_CYCLES = 200
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic phaseAHighDriveIn,
   input wire logic phaseALowDriveIn,
   input wire logic phaseAHighGateOut,
   input wire logic phaseALowGateOut,
   input wire logic phaseBHighGateOut,
   input wire logic phaseBLowGateOut,
   input wire logic phaseCHighGateOut,
   input wire logic phaseCLowGateOut,
   input wire logic outputEnable,
   input wire logic wakeIn,
   input wire logic devFaultOut,
   input wire logic devFaultOe,
   input wire logic devLineOut,
   input wire logic hostLineOut,
   input wire logic [1:0] modeState,
   input wire logic bootstrapSupplyEn,
   input wire logic chargePumpEn,
   input wire logic ampEnable,
   input wire logic [7:0] configReg
);
   logic [15:0] oeLowCnt_reg;
   logic powerUp_reg;
   logic anyGate;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   // Any gate driven
   assign anyGate = phaseAHighGateOut | phaseALowGateOut |
      phaseBHighGateOut | phaseBLowGateOut | phaseCHighGateOut |
      phaseCLowGateOut;

   // Enable-low span and power-up window
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         oeLowCnt_reg <= 16'h0000;
         powerUp_reg <= 1'b1;
      end else begin
         oeLowCnt_reg <= outputEnable ? 16'h0000 : oeLowCnt_reg + 16'h0001;
         powerUp_reg <= powerUp_reg && (modeState == 2'h0);
      end
   end

   // Gate path
   gates_off_a: assert property (
      $fell(outputEnable) |-> ##3 !anyGate)
      else $error("gates still on after enable fall");
   gate_follow_a: assert property (
      $rose(phaseAHighDriveIn) && modeState == 2'h1 && outputEnable &&
      !phaseALowDriveIn && !phaseALowGateOut
      |-> ##3 (phaseAHighGateOut || !outputEnable))
      else $error("high gate did not follow its input");
   // Mode and supplies
   supplies_off_a: assert property (
      modeState != 2'h1 |-> !bootstrapSupplyEn && !chargePumpEn)
      else $error("supplies on outside normal mode");
   amp_standby_a: assert property (
      modeState == 2'h2 |-> ampEnable == !configReg[1])
      else $error("amp enable wrong in standby");
   mode_delay_a: assert property (
      $past(modeState) == 2'h1 && modeState[1]
      |-> oeLowCnt_reg >= 16'(OE_LOW_CYCLES) &&
      oeLowCnt_reg <= 16'(OE_LOW_CYCLES + 6))
      else $error("mode left normal at wrong time");
   sleep_pick_a: assert property (
      $past(modeState) == 2'h1 && modeState[1]
      |-> modeState == (configReg[0] ? 2'h3 : 2'h2))
      else $error("wrong low-power mode chosen");
   wake_exit_a: assert property (
      $past(modeState) == 2'h3 && modeState != 2'h3
      |-> wakeIn && modeState == 2'h0)
      else $error("sleep left without wake");
   // Open-drain pins
   fault_drain_a: assert property (!devFaultOut)
      else $error("fault pin driven high");
   line_drain_a: assert property (!devLineOut && !hostLineOut)
      else $error("serial line driven high");
   startup_fault_a: assert property (
      powerUp_reg && modeState == 2'h0 && !$past(reset) |-> devFaultOe)
      else $error("fault pin released during start-up");

   cover property (modeState == 2'h2);
   cover property (modeState == 2'h3);
   cover property ($fell(devFaultOe));
endmodule // gdm_link_asserts
